/* File: hw/doa_pkg.sv */
package doa_pkg;
  // Object identity and class attributes
  localparam logic [7:0]  DOA_CLASS_CODE = 8'h04;
  localparam logic [15:0] DOA_CLASS_REV  = 16'h0002;
  localparam logic [15:0] DOA_MAX_INST   = 16'h0096;
  // Consuming instance numbers
  localparam logic [15:0] DOA_INST_BASIC = 16'h0014;
  localparam logic [15:0] DOA_INST_EXT   = 16'h0015;
  localparam logic [15:0] DOA_INST_ST    = 16'h0016;
  localparam logic [15:0] DOA_INST_EXTST = 16'h0017;
  localparam logic [15:0] DOA_INST_CFG   = 16'h0064;
  localparam logic [15:0] DOA_UNSET      = 16'h270F;
  // Command byte bit positions
  localparam int DOA_BIT_FWD  = 0;
  localparam int DOA_BIT_REV  = 1;
  localparam int DOA_BIT_RST  = 2;
  localparam int DOA_BIT_NCTL = 5;
  localparam int DOA_BIT_NREF = 6;
  // Frame geometry
  localparam logic [5:0] DOA_LEN_SHORT   = 6'h04;
  localparam logic [5:0] DOA_LEN_LONG    = 6'h06;
  localparam logic [5:0] DOA_POS_ZERO    = 6'h00;
  localparam logic [5:0] DOA_POS_ONE     = 6'h01;
  localparam int         DOA_ENTRIES     = 10;
  localparam int         DOA_FIX_BYTES   = 6;
  localparam int         DOA_ENTRY_BYTES = 4;
  // Attribute selectors on the link
  localparam logic [1:0] DOA_ATTR_REV = 2'h1;
  localparam logic [1:0] DOA_ATTR_MAX = 2'h2;
  localparam logic [1:0] DOA_ATTR_LEN = 2'h3;
  // Controller register offsets and responses
  localparam logic [7:0] DOA_REG_INST   = 8'h00;
  localparam logic [7:0] DOA_REG_SRC    = 8'h04;
  localparam logic [7:0] DOA_REG_TX     = 8'h08;
  localparam logic [7:0] DOA_REG_CMD    = 8'h0C;
  localparam logic [7:0] DOA_REG_STATUS = 8'h10;
  localparam logic [1:0] DOA_RESP_OKAY  = 2'h0;
  localparam logic [1:0] DOA_RESP_ERR   = 2'h2;
  localparam int         DOA_TX_LAST    = 8;
  localparam int         DOA_CMD_CONN   = 0;
  localparam int         DOA_CMD_ATTR   = 1;

  typedef enum logic [1:0] {DOA_IDLE, DOA_RECV, DOA_DROP} doa_state_e;
endpackage

/* File: hw/doa_link_if.sv */
`timescale 1ns/1ps
interface doa_link_if (
  input wire logic clk
);
  logic        wr_valid;
  logic        wr_ready;
  logic        wr_first;
  logic        wr_last;
  logic [7:0]  wr_data;
  logic [15:0] wr_instance;
  logic [31:0] wr_src_ip;
  logic        res_valid;
  logic        res_refused;
  logic        conn_req;
  logic        conn_ack;
  logic        conn_up;
  logic        attr_req;
  logic [1:0]  attr_sel;
  logic        attr_ack;
  logic [15:0] attr_data;

  modport device (
    input  wr_valid, wr_first, wr_last, wr_data, wr_instance, wr_src_ip, conn_req, attr_req, attr_sel,
    output wr_ready, res_valid, res_refused, conn_ack, conn_up, attr_ack, attr_data
  );
  modport host (
    output wr_valid, wr_first, wr_last, wr_data, wr_instance, wr_src_ip, conn_req, attr_req, attr_sel,
    input  wr_ready, res_valid, res_refused, conn_ack, conn_up, attr_ack, attr_data
  );
endinterface

/* File: hw/doa_field_capture.sv */
`timescale 1ns/1ps
module doa_field_capture
  import doa_pkg::*;
#(
  parameter int NB = 4
) (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            clear,
  input  wire logic            take,
  input  wire logic [5:0]      pos,
  input  wire logic [7:0]      data,
  input  wire logic [5:0]      base,
  input  wire logic [5:0]      len,
  output logic      [8*NB-1:0] value
);
  logic [8*NB-1:0] held, next_value;

  // Field shadow, low byte first; shows the byte taken now
  assign value = next_value;
  always_comb begin
    next_value = clear ? '0 : held;
    for (int b = 0; b < NB; b++) begin
      if (take && pos == base + 6'(b) && 6'(b) < len) begin // R15
        next_value[8*b +: 8] = data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      held <= '0;
    end else begin
      held <= next_value;
    end
  end
endmodule

/* File: hw/doa_decoder.sv */
// How it works
// R01: Class 04h holds static assemblies only
// R02: Instances 20-23 fixed, 100 configurable
// R03: Attr 1 revision 0002h, attr 2 max
// R04: Attribute 3 is the frame byte array
// R05: Writes only from permitted source address
// R06: Instance 20: fwd, reset, speed reference
// R07: Instance 21 adds reverse and network selects
// R08: Instance 22: basic byte, speed, torque
// R09: Instance 23: extended byte, speed, torque
// R10: Configurable length from settings, 1-4 bytes
// R11: Unset 9999 entry adds zero bytes
// R12: All unset refuses the connection
// R13: Duplicate targets: lowest entry wins
// R14: Nonexistent target: data discarded, nothing written
// R15: Fixed part first, entries follow, low first
// R16: Fixed part length is 4 or 6
// R17: Refused frames leave outputs unchanged
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module doa_decoder
  import doa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  doa_link_if.device       link,
  input  wire logic [15:0] fixed_format_selection_setting,
  input  wire logic [15:0] user_entry_target_setting [DOA_ENTRIES],
  input  wire logic [1:0]  user_entry_size [DOA_ENTRIES],
  input  wire logic        user_entry_exists [DOA_ENTRIES],
  input  wire logic [31:0] command_source_ip_setting,
  input  wire logic [31:0] command_source_ip_mask,
  output logic             run_fwd,
  output logic             run_rev,
  output logic             fault_reset,
  output logic             control_from_network_select,
  output logic             reference_from_network_select,
  output logic      [15:0] speed_ref,
  output logic      [15:0] torque_ref,
  output logic      [31:0] user_entry_data [DOA_ENTRIES],
  output logic             user_entry_strobe [DOA_ENTRIES]
);
  doa_state_e  state;
  doa_state_e  next_state;
  logic [5:0]  pos;
  logic [5:0]  next_pos;
  logic [15:0] acc_inst;
  logic [15:0] next_acc_inst;
  logic        wr_ready;
  logic        res_valid;
  logic        next_res_valid;
  logic        res_refused;
  logic        next_res_refused;
  logic        conn_up;
  logic        next_conn_up;
  logic        conn_ack;
  logic        attr_ack;
  logic [15:0] attr_data;
  logic [15:0] next_attr_data;
  logic        next_run_fwd;
  logic        next_run_rev;
  logic        next_fault_reset;
  logic        next_nctl;
  logic        next_nref;
  logic [15:0] next_speed_ref;
  logic [15:0] next_torque_ref;
  logic [31:0] next_entry_data [DOA_ENTRIES];
  logic        next_entry_strobe [DOA_ENTRIES];
  logic [5:0]  fix_len;
  logic [5:0]  cfg_len;
  logic        all_unset;
  logic        dup;
  logic        ent_live [DOA_ENTRIES];
  logic [5:0]  ent_len [DOA_ENTRIES];
  logic [5:0]  ent_base [DOA_ENTRIES];
  logic [15:0] cur_inst;
  logic [15:0] lay_inst;
  logic [5:0]  exp_len;
  logic [5:0]  fix_part_len;
  logic [5:0]  byte_pos;
  logic        permitted;
  logic        start_ok;
  logic        take;
  logic        commit;
  logic        is_cfg;
  logic [47:0] fix_value;
  logic [31:0] ent_value [DOA_ENTRIES];

  // Length of a fixed layout; anything else, unset included, has none
  function automatic logic [5:0] fixed_len(input logic [15:0] inst);
    unique case (inst)
      DOA_INST_BASIC, DOA_INST_EXT: fixed_len = DOA_LEN_SHORT; // R01 R02 R16
      DOA_INST_ST, DOA_INST_EXTST:  fixed_len = DOA_LEN_LONG;
      default:                      fixed_len = DOA_POS_ZERO; // R11
    endcase
  endfunction

  // Configurable frame layout from the settings
  always_comb begin
    fix_len   = fixed_len(fixed_format_selection_setting); // R16
    cfg_len   = fix_len;
    all_unset = (fixed_format_selection_setting == DOA_UNSET);
    dup       = 1'b0;
    for (int k = 0; k < DOA_ENTRIES; k++) begin
      dup = 1'b0;
      for (int j = 0; j < k; j++) begin
        if (user_entry_target_setting[j] == user_entry_target_setting[k]) begin
          dup = 1'b1; // R13
        end
      end
      ent_live[k] = (user_entry_target_setting[k] != DOA_UNSET) && !dup; // R11 R13
      ent_len[k]  = ent_live[k] ? {4'h0, user_entry_size[k]} + DOA_POS_ONE : DOA_POS_ZERO; // R10
      ent_base[k] = cfg_len; // R15
      cfg_len     = cfg_len + ent_len[k];
      if (user_entry_target_setting[k] != DOA_UNSET) begin
        all_unset = 1'b0;
      end
    end
  end

  // Frame admission and byte placement
  always_comb begin
    cur_inst     = link.wr_first ? link.wr_instance : acc_inst;
    is_cfg       = (cur_inst == DOA_INST_CFG);
    lay_inst     = is_cfg ? fixed_format_selection_setting : cur_inst;
    exp_len      = is_cfg ? cfg_len : fixed_len(cur_inst);
    fix_part_len = is_cfg ? fix_len : exp_len;
    byte_pos     = link.wr_first ? DOA_POS_ZERO : pos;
    permitted    = ((link.wr_src_ip ^ command_source_ip_setting) & command_source_ip_mask) == '0; // R05
    start_ok     = conn_up && permitted && exp_len != DOA_POS_ZERO;
    take         = link.wr_valid && wr_ready && (link.wr_first ? start_ok : state == DOA_RECV); // R04
    commit       = take && link.wr_last && (byte_pos + DOA_POS_ONE == exp_len); // R17
  end

  doa_field_capture #(
    .NB (DOA_FIX_BYTES)
  ) u_fix (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (link.wr_valid && link.wr_first),
    .take    (take),
    .pos     (byte_pos),
    .data    (link.wr_data),
    .base    (DOA_POS_ZERO),
    .len     (fix_part_len),
    .value   (fix_value)
  );

  for (genvar g = 0; g < DOA_ENTRIES; g++) begin : g_ent
    doa_field_capture #(
      .NB (DOA_ENTRY_BYTES)
    ) u_ent (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (link.wr_valid && link.wr_first),
      .take    (take && is_cfg),
      .pos     (byte_pos),
      .data    (link.wr_data),
      .base    (ent_base[g]),
      .len     (ent_len[g]),
      .value   (ent_value[g])
    );
  end

  // Receive sequencing and result reporting
  always_comb begin
    next_state       = state;
    next_pos         = pos;
    next_acc_inst    = acc_inst;
    next_res_valid   = 1'b0;
    next_res_refused = res_refused;
    if (link.wr_valid && wr_ready) begin
      if (link.wr_first) begin
        next_acc_inst = link.wr_instance;
        next_state    = start_ok ? DOA_RECV : DOA_DROP; // R05
        next_pos      = DOA_POS_ONE;
      end else if (state != DOA_IDLE) begin
        next_pos = pos + DOA_POS_ONE;
      end
      if (link.wr_last && (link.wr_first || state != DOA_IDLE)) begin
        next_state       = DOA_IDLE;
        next_res_valid   = 1'b1;
        next_res_refused = !commit; // R17
      end
    end
  end

  // Command decode, applied only on a complete accepted frame
  always_comb begin
    next_run_fwd     = run_fwd;
    next_run_rev     = run_rev;
    next_fault_reset = fault_reset;
    next_nctl        = control_from_network_select;
    next_nref        = reference_from_network_select;
    next_speed_ref   = speed_ref;
    next_torque_ref  = torque_ref;
    for (int k = 0; k < DOA_ENTRIES; k++) begin
      next_entry_data[k]   = user_entry_data[k];
      next_entry_strobe[k] = 1'b0;
    end
    if (commit && fix_part_len != DOA_POS_ZERO) begin
      next_run_fwd     = fix_value[DOA_BIT_FWD]; // R06 R08
      next_fault_reset = fix_value[DOA_BIT_RST];
      next_speed_ref   = fix_value[31:16];
      if (lay_inst == DOA_INST_EXT || lay_inst == DOA_INST_EXTST) begin
        next_run_rev = fix_value[DOA_BIT_REV]; // R07 R09
        next_nctl    = fix_value[DOA_BIT_NCTL];
        next_nref    = fix_value[DOA_BIT_NREF];
      end
      if (fix_part_len == DOA_LEN_LONG) begin
        next_torque_ref = fix_value[47:32]; // R08 R09
      end
    end
    for (int k = 0; k < DOA_ENTRIES; k++) begin
      if (commit && is_cfg && ent_live[k] && user_entry_exists[k]) begin // R14
        next_entry_data[k]   = ent_value[k];
        next_entry_strobe[k] = 1'b1;
      end
    end
  end

  // Connection and attribute answers
  always_comb begin
    next_conn_up   = conn_up;
    next_attr_data = attr_data;
    if (link.conn_req) begin
      next_conn_up = !all_unset; // R12
    end
    if (link.attr_req) begin
      unique case (link.attr_sel)
        DOA_ATTR_REV: next_attr_data = DOA_CLASS_REV; // R03
        DOA_ATTR_MAX: next_attr_data = DOA_MAX_INST;
        DOA_ATTR_LEN: next_attr_data = {10'h000, cfg_len};
        default:      next_attr_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state                         <= DOA_IDLE;
      pos                           <= DOA_POS_ZERO;
      acc_inst                      <= 16'h0000;
      wr_ready                      <= 1'b0;
      res_valid                     <= 1'b0;
      res_refused                   <= 1'b0;
      conn_up                       <= 1'b0;
      conn_ack                      <= 1'b0;
      attr_ack                      <= 1'b0;
      attr_data                     <= 16'h0000;
      run_fwd                       <= 1'b0;
      run_rev                       <= 1'b0;
      fault_reset                   <= 1'b0;
      control_from_network_select   <= 1'b0;
      reference_from_network_select <= 1'b0;
      speed_ref                     <= 16'h0000;
      torque_ref                    <= 16'h0000;
      for (int k = 0; k < DOA_ENTRIES; k++) begin
        user_entry_data[k]   <= 32'h0000_0000;
        user_entry_strobe[k] <= 1'b0;
      end
    end else begin
      state                         <= next_state;
      pos                           <= next_pos;
      acc_inst                      <= next_acc_inst;
      wr_ready                      <= 1'b1;
      res_valid                     <= next_res_valid;
      res_refused                   <= next_res_refused;
      conn_up                       <= next_conn_up;
      conn_ack                      <= link.conn_req;
      attr_ack                      <= link.attr_req;
      attr_data                     <= next_attr_data;
      run_fwd                       <= next_run_fwd;
      run_rev                       <= next_run_rev;
      fault_reset                   <= next_fault_reset;
      control_from_network_select   <= next_nctl;
      reference_from_network_select <= next_nref;
      speed_ref                     <= next_speed_ref;
      torque_ref                    <= next_torque_ref;
      for (int k = 0; k < DOA_ENTRIES; k++) begin
        user_entry_data[k]   <= next_entry_data[k];
        user_entry_strobe[k] <= next_entry_strobe[k];
      end
    end
  end

  assign link.wr_ready    = wr_ready;
  assign link.res_valid   = res_valid;
  assign link.res_refused = res_refused;
  assign link.conn_ack    = conn_ack;
  assign link.conn_up     = conn_up;
  assign link.attr_ack    = attr_ack;
  assign link.attr_data   = attr_data;
endmodule

/* File: hw/doa_scanner.sv */
`timescale 1ns/1ps
module doa_scanner
  import doa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  doa_link_if.host         link
);
  typedef struct packed {
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        aw_held, w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        wr_valid, wr_first, wr_last, frame_open;
    logic [7:0]  wr_data;
    logic [15:0] wr_instance;
    logic [31:0] wr_src_ip;
    logic        conn_req, attr_req;
    logic [1:0]  attr_sel;
    logic        conn_up, done, refused, attr_valid;
    logic [15:0] attr_data;
  } doa_host_s;

  doa_host_s r;
  doa_host_s next_r;

  // Register bus slave and link driver
  always_comb begin
    next_r          = r;
    next_r.conn_req = 1'b0;
    next_r.attr_req = 1'b0;
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.wr_valid && link.wr_ready) begin
      next_r.wr_valid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid && !(r.aw_addr == DOA_REG_TX && r.wr_valid)) begin
      next_r.aw_held = 1'b0;
      next_r.w_held  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = DOA_RESP_OKAY;
      unique case (r.aw_addr)
        DOA_REG_INST: next_r.wr_instance = r.w_data[15:0];
        DOA_REG_SRC:  next_r.wr_src_ip   = r.w_data;
        DOA_REG_TX: begin
          next_r.wr_valid   = 1'b1; // R15
          next_r.wr_data    = r.w_data[7:0];
          next_r.wr_last    = r.w_data[DOA_TX_LAST];
          next_r.wr_first   = !r.frame_open;
          next_r.frame_open = !r.w_data[DOA_TX_LAST];
        end
        DOA_REG_CMD: begin
          next_r.conn_req   = r.w_data[DOA_CMD_CONN];
          next_r.attr_req   = r.w_data[DOA_CMD_ATTR];
          next_r.attr_sel   = r.w_data[9:8];
          next_r.attr_valid = r.attr_valid && !r.w_data[DOA_CMD_ATTR];
        end
        default: next_r.bresp = DOA_RESP_ERR;
      endcase
    end
    // Link answers; a set in the same cycle wins over a clear
    if (link.res_valid) begin
      next_r.done    = !link.res_refused;
      next_r.refused = link.res_refused;
    end
    if (link.conn_ack) begin
      next_r.conn_up = link.conn_up;
    end
    if (link.attr_ack) begin
      next_r.attr_valid = 1'b1;
      next_r.attr_data  = link.attr_data;
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = DOA_RESP_OKAY;
      unique case (s_axi_araddr)
        DOA_REG_INST:   next_r.rdata = {16'h0000, r.wr_instance};
        DOA_REG_SRC:    next_r.rdata = r.wr_src_ip;
        DOA_REG_TX:     next_r.rdata = {30'h0000_0000, r.frame_open, r.wr_valid};
        DOA_REG_CMD:    next_r.rdata = 32'h0000_0000;
        DOA_REG_STATUS: next_r.rdata = {r.attr_data, 12'h000, r.attr_valid, r.refused, r.done, r.conn_up};
        default: begin
          next_r.rdata = 32'h0000_0000;
          next_r.rresp = DOA_RESP_ERR;
        end
      endcase
    end
    next_r.awready = !next_r.aw_held;
    next_r.wready  = !next_r.w_held;
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready    = r.awready;
  assign s_axi_wready     = r.wready;
  assign s_axi_bvalid     = r.bvalid;
  assign s_axi_bresp      = r.bresp;
  assign s_axi_arready    = r.arready;
  assign s_axi_rvalid     = r.rvalid;
  assign s_axi_rdata      = r.rdata;
  assign s_axi_rresp      = r.rresp;
  assign link.wr_valid    = r.wr_valid;
  assign link.wr_first    = r.wr_first;
  assign link.wr_last     = r.wr_last;
  assign link.wr_data     = r.wr_data;
  assign link.wr_instance = r.wr_instance;
  assign link.wr_src_ip   = r.wr_src_ip;
  assign link.conn_req    = r.conn_req;
  assign link.attr_req    = r.attr_req;
  assign link.attr_sel    = r.attr_sel;
endmodule

/* File: verif/doa_link_asserts.sv */
`timescale 1ns/1ps
module doa_link_asserts
  import doa_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic        wr_first,
  input wire logic        wr_last,
  input wire logic [7:0]  wr_data,
  input wire logic        res_valid,
  input wire logic        res_refused,
  input wire logic        conn_req,
  input wire logic        conn_ack,
  input wire logic        conn_up,
  input wire logic        attr_req,
  input wire logic [1:0]  attr_sel,
  input wire logic        attr_ack,
  input wire logic [15:0] attr_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Frame result timing against the last byte
  res_after_a: assert property (wr_valid && wr_ready && wr_last |=> res_valid)
    else $error("no result after last byte");
  res_cause_a: assert property (res_valid |-> $past(wr_valid && wr_ready && wr_last))
    else $error("result without last byte");
  // Offered byte held until taken
  byte_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_data, wr_first, wr_last}))
    else $error("offered byte changed");
  // Refusal flag moves only with a result
  refused_hold_a: assert property (!res_valid |-> $stable(res_refused))
    else $error("refusal flag moved");
  // Connection answer and state
  conn_ack_a: assert property (conn_req |=> conn_ack)
    else $error("connection not answered");
  conn_state_a: assert property ($changed(conn_up) |-> conn_ack)
    else $error("connection state moved alone");
  // Class attribute values
  attr_rev_a: assert property (attr_req && attr_sel == DOA_ATTR_REV |=> attr_ack && attr_data == DOA_CLASS_REV)
    else $error("wrong revision answer");
  attr_max_a: assert property (attr_req && attr_sel == DOA_ATTR_MAX |=> attr_ack && attr_data == DOA_MAX_INST)
    else $error("wrong max instance answer");
  attr_hold_a: assert property (!attr_ack |-> $stable(attr_data))
    else $error("attribute data moved");
endmodule

/* File: verif/drive_output_assembly_decoder_bench.sv */
`timescale 1ns/1ps
module drive_output_assembly_decoder_bench
  import doa_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, ip_set, ip_mask, ued [DOA_ENTRIES];
  logic [1:0]  s_axi_bresp, s_axi_rresp, sz [DOA_ENTRIES];
  logic [15:0] fix_sel, tgt [DOA_ENTRIES], speed_ref, torque_ref;
  logic        ex [DOA_ENTRIES], ues [DOA_ENTRIES];
  logic        run_fwd, run_rev, fault_reset, nctl, nref;
  int          miscompares = 0, samples_checked = 0, strobes = 0;

  doa_link_if link (.clk(clk));
  doa_scanner i_doa_scanner (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .link(link));
  doa_decoder i_doa_decoder (.clk, .sys_rst, .link(link), .fixed_format_selection_setting(fix_sel),
    .user_entry_target_setting(tgt), .user_entry_size(sz), .user_entry_exists(ex), .command_source_ip_setting(ip_set),
    .command_source_ip_mask(ip_mask), .run_fwd, .run_rev, .fault_reset, .control_from_network_select(nctl),
    .reference_from_network_select(nref), .speed_ref, .torque_ref, .user_entry_data(ued), .user_entry_strobe(ues));
  doa_link_asserts i_doa_link_asserts (.clk, .sys_rst, .wr_valid(link.wr_valid), .wr_ready(link.wr_ready),
    .wr_first(link.wr_first), .wr_last(link.wr_last), .wr_data(link.wr_data), .res_valid(link.res_valid),
    .res_refused(link.res_refused), .conn_req(link.conn_req), .conn_ack(link.conn_ack), .conn_up(link.conn_up),
    .attr_req(link.attr_req), .attr_sel(link.attr_sel), .attr_ack(link.attr_ack), .attr_data(link.attr_data));

  // Clock, strobe tally and watchdog
  always #4 clk = ~clk;
  always @(posedge clk) begin
    strobes <= strobes + 32'(ues[0] === 1'b1) + 32'(ues[4] === 1'b1) + 16 * 32'(ues[1] === 1'b1 || ues[3] === 1'b1);
  end
  initial begin
    #400_000;
    miscompares++;
    end_of_test();
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped on its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic frame(input logic [15:0] inst, input logic [7:0] b [$]);
    axi_wr(DOA_REG_INST, {16'h0, inst}, DOA_RESP_OKAY);
    foreach (b[i]) axi_wr(DOA_REG_TX, {23'h0, i == b.size() - 1, b[i]}, DOA_RESP_OKAY);
    repeat (4) @(posedge clk);
  endtask

  // Command bits in order fwd, rev, reset, net control, net reference
  task automatic outs(input logic [4:0] c, input logic [15:0] s, input logic [15:0] t);
    chk({27'h0, run_fwd, run_rev, fault_reset, nctl, nref}, {27'h0, c});
    chk({speed_ref, torque_ref}, {s, t});
  endtask

  task automatic attr(input logic [1:0] sel, input logic [15:0] exp);
    axi_wr(DOA_REG_CMD, {22'h0, sel, 8'h02}, DOA_RESP_OKAY);
    axi_rd(DOA_REG_STATUS, DOA_RESP_OKAY);
    chk({16'h0, rd[31:16]}, {16'h0, exp});
  endtask

  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata  = '0;
    fix_sel = DOA_INST_BASIC;
    tgt = '{16'h0001, 16'h0001, DOA_UNSET, 16'h0003, 16'h0004, DOA_UNSET, DOA_UNSET, DOA_UNSET, DOA_UNSET, DOA_UNSET};
    sz  = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    ex  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    ip_set  = 32'h0a00_0001;
    ip_mask = 32'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    outs(5'b00000, 16'h0, 16'h0);
    axi_wr(DOA_REG_SRC, 32'h0a00_0001, DOA_RESP_OKAY);
    axi_wr(DOA_REG_CMD, 32'h1, DOA_RESP_OKAY);
    axi_rd(DOA_REG_STATUS, DOA_RESP_OKAY);
    chk({31'h0, rd[0]}, 32'h1);
    frame(DOA_INST_BASIC, '{8'h05, 8'h00, 8'h34, 8'h12});
    outs(5'b10100, 16'h1234, 16'h0);
    frame(DOA_INST_EXT, '{8'h62, 8'h00, 8'hcd, 8'hab});
    outs(5'b01011, 16'habcd, 16'h0);
    frame(DOA_INST_ST, '{8'h01, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44});
    outs(5'b11011, 16'h2211, 16'h4433);
    frame(DOA_INST_EXTST, '{8'h46, 8'h00, 8'h66, 8'h55, 8'h88, 8'h77});
    outs(5'b01101, 16'h5566, 16'h7788);
    frame(DOA_INST_BASIC, '{8'h01, 8'h00, 8'h99});
    outs(5'b01101, 16'h5566, 16'h7788);
    axi_rd(DOA_REG_STATUS, DOA_RESP_OKAY);
    chk({30'h0, rd[2:1]}, 32'h2);
    ip_set  <= 32'h0a00_0002;
    ip_mask <= 32'hffff_ffff;
    frame(DOA_INST_BASIC, '{8'h01, 8'h00, 8'h01, 8'h00});
    outs(5'b01101, 16'h5566, 16'h7788);
    ip_mask <= 32'h0;
    frame(DOA_INST_CFG, '{8'h00, 8'h00, 8'h78, 8'h56, 8'hcd, 8'hab, 8'hee, 8'h11, 8'h22, 8'h33, 8'h44});
    outs(5'b01001, 16'h5678, 16'h7788);
    chk(ued[0], 32'h0000_abcd);
    chk(ued[1], 32'h0);
    chk(ued[3], 32'h0);
    chk(ued[4], 32'h4433_2211);
    chk(32'(strobes), 32'h2);
    attr(DOA_ATTR_REV, DOA_CLASS_REV);
    attr(DOA_ATTR_MAX, DOA_MAX_INST);
    attr(DOA_ATTR_LEN, 16'h000b);
    axi_wr(8'h40, 32'h0, DOA_RESP_ERR);
    axi_wr(DOA_REG_STATUS, 32'h0, DOA_RESP_ERR);
    axi_rd(8'h40, DOA_RESP_ERR);
    chk(rd, 32'h0);
    fix_sel <= DOA_UNSET;
    foreach (tgt[i]) tgt[i] <= DOA_UNSET;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    outs(5'b00000, 16'h0, 16'h0);
    axi_wr(DOA_REG_CMD, 32'h1, DOA_RESP_OKAY);
    axi_rd(DOA_REG_STATUS, DOA_RESP_OKAY);
    chk({31'h0, rd[0]}, 32'h0);
    end_of_test();
  end
endmodule
